// ==== cscc_top.sv ====
// Purpose: Configuration and start control of the capacitive-sense converter.
// Assumes: Register bus inputs and timer overflow pulses are synchronous to clk_sys.
// Notes: The analogue front end is outside; it takes sample_req and returns samples.
`timescale 1ns/1ps
module cscc_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Special-function register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Channel selection held by neighbouring registers.
  input wire logic [7:0] channel_mask_low,
  input wire logic [5:0] channel_mask_high,
  input wire logic [4:0] input_mux_select,
  input wire logic [4:0] scan_first_channel,
  input wire logic [4:0] scan_last_channel,
  // Timer overflow pulses, index n for timer n.
  input wire logic [3:0] timer_overflow,
  // Converter front end.
  output logic sample_req,
  output logic [4:0] conv_channel,
  output logic multi_channel_short_enable,
  output logic [13:0] short_mask,
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  // Status seen by neighbouring logic.
  output logic conversion_in_progress,
  output logic conversion_done_flag,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte
);

  // Control states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_NEXT = 3'b100
  } cscc_state_t;

  // Controller state.
  cscc_state_t state;
  cscc_state_t next_state;

  // Configuration fields.
  logic [7:0] cap_sense_config;
  logic scan_mask_enable;
  cscc_pkg::cscc_mode_t start_mode_select;
  logic multi_enable;
  logic [2:0] accumulate_count_select;
  logic [13:0] mask_all;

  // Decoded writes and starts.
  logic wr_config;
  logic wr_ctrl;
  logic busy_write;
  logic timer_hit;
  logic start_now;
  logic mux_mode;
  logic pass_done;

  // Sequencer and accumulator controls.
  logic seq_load;
  logic seq_load_mux;
  logic seq_adv;
  logic acc_start;
  logic seq_pass_end;
  logic [4:0] seq_ch;

  // Link to the accumulator.
  cscc_acc_if acc_bus ();

  // Configuration fields.
  assign scan_mask_enable = cap_sense_config[cscc_pkg::CFG_MASK_EN_BIT];
  assign start_mode_select = cscc_pkg::cscc_mode_t'(
    cap_sense_config[cscc_pkg::CFG_MODE_LSB +: 3]);
  assign multi_enable = cap_sense_config[cscc_pkg::CFG_MCEN_BIT];
  assign accumulate_count_select = cap_sense_config[cscc_pkg::CFG_ACU_LSB +: 3];
  assign mask_all = {channel_mask_high, channel_mask_low};

  // Address decode of the two writable registers.
  assign wr_config = sfr_wr && (sfr_addr == cscc_pkg::ADDR_CONFIG);
  assign wr_ctrl = sfr_wr && (sfr_addr == cscc_pkg::ADDR_CTRL);
  assign busy_write = wr_ctrl && sfr_wdata[cscc_pkg::CTRL_BUSY_BIT];

  // Configuration register; every field is writable.
  // Reserved codes are kept as written.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_sense_config <= cscc_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      cap_sense_config <= sfr_wdata;
    end
  end

  // Overflow source picked by the start mode; the codes do not follow timer numbers.
  // Other overflows are simply not seen.
  always_comb begin
    timer_hit = 1'b0;
    case (start_mode_select)
      cscc_pkg::MODE_TMR0: timer_hit = timer_overflow[0];
      cscc_pkg::MODE_TMR2: timer_hit = timer_overflow[2];
      cscc_pkg::MODE_TMR1: timer_hit = timer_overflow[1];
      cscc_pkg::MODE_TMR3: timer_hit = timer_overflow[3];
      default: timer_hit = 1'b0;
    endcase
  end

  // Start condition while idle; mode 101 without masking never starts.
  // Timer modes fall to the default branch.
  always_comb begin
    start_now = 1'b0;
    case (start_mode_select)
      cscc_pkg::MODE_SW: start_now = busy_write;
      cscc_pkg::MODE_SCAN_ONCE: start_now = busy_write && scan_mask_enable;
      cscc_pkg::MODE_CONT_MUX: start_now = busy_write;
      cscc_pkg::MODE_CONT_SCAN: start_now = busy_write;
      default: start_now = timer_hit;
    endcase
  end

  // Single-channel modes take the channel straight from the input mux selection.
  assign mux_mode = (start_mode_select != cscc_pkg::MODE_SCAN_ONCE)
    && (start_mode_select != cscc_pkg::MODE_CONT_SCAN);

  // A shorted node is one input, so a scan pass is a single conversion.
  assign pass_done = seq_pass_end || multi_enable;

  // Next-state and step decisions.
  // NEXT is a one-cycle turn: the mode is read again there,
  // so a continuous run ends at a conversion boundary.
  always_comb begin
    next_state = state;
    seq_load = 1'b0;
    seq_load_mux = mux_mode;
    seq_adv = 1'b0;
    acc_start = 1'b0;
    unique case (state)
      // Idle: wait for a start.
      ST_IDLE: begin
        if (start_now) begin
          seq_load = 1'b1;
          acc_start = 1'b1;
          next_state = ST_RUN;
        end
      end

      ST_RUN: begin
        // Triggers here are dropped, so a running conversion is never restarted.
        if (acc_bus.done) begin
          next_state = ST_NEXT;
        end
      end

      // Turn: the mode picks what follows.
      ST_NEXT: begin
        next_state = ST_IDLE;
        case (start_mode_select)
          // Same channel again.
          cscc_pkg::MODE_CONT_MUX: begin
            seq_load = 1'b1;
            acc_start = 1'b1;
            next_state = ST_RUN;
          end

          // Next masked channel, or stop.
          cscc_pkg::MODE_SCAN_ONCE: begin
            if (scan_mask_enable && !pass_done) begin
              seq_adv = 1'b1;
              acc_start = 1'b1;
              next_state = ST_RUN;
            end
          end

          // Wrap or step to the next channel.
          cscc_pkg::MODE_CONT_SCAN: begin
            seq_load = pass_done;
            seq_adv = !pass_done;
            acc_start = 1'b1;
            next_state = ST_RUN;
          end
          default: next_state = ST_IDLE;
        endcase
      end
    endcase
  end

  // State register.
  // One-hot codes make each state one bit.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Busy covers the whole run, including the turn between back-to-back conversions.
  // It follows next_state so it rises with sample_req.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conversion_in_progress <= 1'b0;
    end else begin
      conversion_in_progress <= (next_state != ST_IDLE);
    end
  end

  // Done flag: a completion in the cycle of a clearing write still sets it.
  // Only software writes can clear it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conversion_done_flag <= 1'b0;
    end else if (acc_bus.done) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      conversion_done_flag <= sfr_wdata[cscc_pkg::CTRL_DONE_BIT];
    end
  end

  // Result pair, replaced only when a conversion completes.
  // No read latch: read both bytes while idle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result_high_byte <= cscc_pkg::RESULT_RESET[15:8];
      result_low_byte <= cscc_pkg::RESULT_RESET[7:0];
    end else if (acc_bus.done) begin
      result_high_byte <= acc_bus.sum[15:8];
      result_low_byte <= acc_bus.sum[7:0];
    end
  end

  // Shorting control; the masks have no effect while masking is off.
  // Masking off forces an empty set.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      multi_channel_short_enable <= 1'b0;
      short_mask <= '0;
    end else begin
      multi_channel_short_enable <= multi_enable;
      short_mask <= (multi_enable && scan_mask_enable) ? mask_all : 14'h0000;
    end
  end

  // Read data, registered one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        cscc_pkg::ADDR_CONFIG: sfr_rdata <= cap_sense_config;
        // Only the done and busy bits exist here.
        cscc_pkg::ADDR_CTRL: begin
          sfr_rdata <= 8'h00;
          sfr_rdata[cscc_pkg::CTRL_DONE_BIT] <= conversion_done_flag;
          sfr_rdata[cscc_pkg::CTRL_BUSY_BIT] <= conversion_in_progress;
        end
        cscc_pkg::ADDR_RES_LO: sfr_rdata <= result_low_byte;
        cscc_pkg::ADDR_RES_HI: sfr_rdata <= result_high_byte;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Accumulator request; the code is sampled with the start pulse.
  assign acc_bus.start = acc_start;
  assign acc_bus.code = accumulate_count_select;

  // Channel stepping; the channel register changes on the same edge as sample_req.
  // Load and advance never coincide.
  cscc_seq #(
    .NUM_CH(cscc_pkg::NUM_CH),
    .CH_W(cscc_pkg::CH_W)
  ) u_seq (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(seq_load),
    .load_mux(seq_load_mux),
    .advance(seq_adv),
    .mask_en(scan_mask_enable),
    .mask(mask_all),
    .first(scan_first_channel),
    .last(scan_last_channel),
    .mux(input_mux_select),
    .ch(seq_ch),
    .pass_end(seq_pass_end)
  );

  // Sample summing.
  cscc_accum u_accum (
    .clk_sys(clk_sys),
    .srst(srst),
    .acc(acc_bus.acc),
    .sample_req(sample_req),
    .sample_valid(sample_valid),
    .sample_data(sample_data)
  );

  // The channel comes straight from the sequencer's register.
  assign conv_channel = seq_ch;

endmodule : cscc_top

// ==== cscc_pkg.sv ====
// Purpose: Shared constants and types for the capacitive-sense conversion control.
// Assumes: An 8-bit special-function register bus and a 200 MHz system clock.
// Notes: Every offset, field position and reset value is named here once.
//
// How it works
// - Mask enable bit 7 off ignores both channel masks; on, masks pick scan channels.
// - Start mode 000 starts one conversion per software write of 1 to busy.
// - Mode 001 starts on timer 0 overflow, mode 010 on timer 2 overflow.
// - Mode 011 starts on timer 1 overflow, mode 100 on timer 3 overflow.
// - Mode 110 converts back to back on mux channel; 101 unused without masking.
// - Masking off, mode 111 loops continuously from first to last scan channel.
// - Masking on, mode 101 makes one pass over masked channels, then stops.
// - Masking on, mode 111 scans masked channels repeatedly without stopping.
// - Multi-channel bit 3 shorts masked channels into one node converted once.
// - Accumulate field 000, 001, 010 sums 1, 4, 8 samples per result.
// - Accumulate 011, 100, 101 sums 16, 32, 64 samples; 110, 111 reserved.
// - Configuration register resets to zero: software start, one sample, features off.
// - Busy bit reads 1 while a conversion runs, 0 otherwise.
// - Each finished conversion sets a done flag only software clears.
// - Latest 16-bit result is held as a high and low byte pair.
package cscc_pkg;

  // Register addresses on the special-function register bus.
  localparam logic [7:0] ADDR_CONFIG = 8'hAA;
  localparam logic [7:0] ADDR_CTRL = 8'hB0;
  localparam logic [7:0] ADDR_RES_LO = 8'hED;
  localparam logic [7:0] ADDR_RES_HI = 8'hEE;

  // Field positions of the configuration and control registers.
  localparam int CFG_MASK_EN_BIT = 7;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_MCEN_BIT = 3;
  localparam int CFG_ACU_LSB = 0;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Sizes of the channel set and the result.
  localparam int NUM_CH = 14;
  localparam int CH_W = 5;
  localparam int RESULT_W = 16;
  localparam int CNT_W = 7;

  // Start-of-conversion modes.
  typedef enum logic [2:0] {
    MODE_SW = 3'h0,
    MODE_TMR0 = 3'h1,
    MODE_TMR2 = 3'h2,
    MODE_TMR1 = 3'h3,
    MODE_TMR3 = 3'h4,
    MODE_SCAN_ONCE = 3'h5,
    MODE_CONT_MUX = 3'h6,
    MODE_CONT_SCAN = 3'h7
  } cscc_mode_t;

  // Samples summed per result for each accumulate code.
  function automatic logic [CNT_W-1:0] cscc_samples(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = 7'h01;
    case (code)
      3'h1: n = 7'h04;
      3'h2: n = 7'h08;
      3'h3: n = 7'h10;
      3'h4: n = 7'h20;
      3'h5: n = 7'h40;
      default: n = 7'h01;
    endcase
    return n;
  endfunction : cscc_samples

endpackage : cscc_pkg

// ==== cscc_acc_if.sv ====
// Purpose: Carries a conversion request and its summed result between control and accumulator.
// Assumes: Both ends run on clk_sys.
// Notes: start and done are one-cycle pulses; sum is stable after done.
`timescale 1ns/1ps
interface cscc_acc_if;
  logic start;
  logic [2:0] code;
  logic done;
  logic [cscc_pkg::RESULT_W-1:0] sum;
  modport ctrl (output start, output code, input done, input sum);
  modport acc (input start, input code, output done, output sum);
endinterface : cscc_acc_if

// ==== cscc_accum.sv ====
// Purpose: Requests samples from the converter and sums them into one result.
// Assumes: The converter answers each sample_req with one sample_valid pulse.
// Notes: The sum saturates at full scale instead of wrapping.
`timescale 1ns/1ps
module cscc_accum (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Control side.
  cscc_acc_if.acc acc,
  // Converter side.
  output logic sample_req,
  input wire logic sample_valid,
  input wire logic [cscc_pkg::RESULT_W-1:0] sample_data
);

  logic [cscc_pkg::CNT_W-1:0] remaining;
  logic [cscc_pkg::RESULT_W:0] wide;

  // One bit of headroom detects overflow of the running sum.
  always_comb begin
    wide = {1'b0, acc.sum} + {1'b0, sample_data};
  end

  // Running sum and samples still owed; 64 full-scale samples would wrap, so saturate.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc.sum <= cscc_pkg::RESULT_RESET;
      remaining <= '0;
    end else if (acc.start) begin
      acc.sum <= cscc_pkg::RESULT_RESET;
      remaining <= cscc_pkg::cscc_samples(acc.code);
    end else if (sample_valid && remaining != '0) begin
      acc.sum <= wide[cscc_pkg::RESULT_W] ? 16'hFFFF : wide[cscc_pkg::RESULT_W-1:0];
      remaining <= remaining - 7'h01;
    end
  end

  // Sample requests and the closing done pulse.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sample_req <= 1'b0;
      acc.done <= 1'b0;
    end else begin
      sample_req <= acc.start;
      acc.done <= 1'b0;
      if (sample_valid && remaining != '0) begin
        if (remaining == 7'h01) begin
          acc.done <= 1'b1;
        end else begin
          sample_req <= 1'b1;
        end
      end
    end
  end

endmodule : cscc_accum

// ==== cscc_seq.sv ====
// Purpose: Holds the channel under conversion and steps it through a range or mask.
// Assumes: load and advance never arrive in the same cycle.
// Notes: pass_end is combinational and marks the last channel of the pass.
`timescale 1ns/1ps
module cscc_seq #(
  parameter int NUM_CH = 14,
  parameter int CH_W = 5
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Stepping control.
  input wire logic load,
  input wire logic load_mux,
  input wire logic advance,
  // Channel selection sources.
  input wire logic mask_en,
  input wire logic [NUM_CH-1:0] mask,
  input wire logic [CH_W-1:0] first,
  input wire logic [CH_W-1:0] last,
  input wire logic [CH_W-1:0] mux,
  // Current channel.
  output logic [CH_W-1:0] ch,
  output logic pass_end
);

  logic [CH_W-1:0] lowest;
  logic [CH_W-1:0] above;
  logic any_above;

  // Lowest masked channel, and lowest masked channel above the current one.
  always_comb begin
    lowest = '0;
    above = '0;
    any_above = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        lowest = CH_W'(i);
      end
      if (mask[i] && CH_W'(i) > ch) begin
        above = CH_W'(i);
        any_above = 1'b1;
      end
    end
    pass_end = mask_en ? !any_above : (ch >= last);
  end

  // Channel register; the mask is consulted only while masking is on.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch <= '0;
    end else if (load) begin
      ch <= load_mux ? mux : (mask_en ? lowest : first);
    end else if (advance) begin
      ch <= mask_en ? above : CH_W'(ch + 1'b1);
    end
  end

endmodule : cscc_seq

// ==== cscc_front_model.sv ====
// Purpose: Behavioural front end answering each sample request with one sample.
// Assumes: Requests are one-cycle pulses; slow adds two cycles of latency.
// Notes: Outside the strobe the data shows the inverse of its last value.
`timescale 1ns/1ps
module cscc_front_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Request side.
  input wire logic sample_req,
  input wire logic slow,
  input wire logic [15:0] level,
  // Sample return.
  output logic sample_valid,
  output logic [15:0] sample_data
);
  logic pend;
  logic [2:0] wait_cnt;
  // One request is outstanding at a time; the answer comes one or three cycles later.
  always_ff @(posedge clk_sys) begin
    sample_valid <= 1'b0;
    if (srst) begin
      pend <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (sample_req) begin
      pend <= 1'b1;
      wait_cnt <= slow ? 3'h2 : 3'h0;
    end else if (pend && wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (pend) begin
      pend <= 1'b0;
      sample_valid <= 1'b1;
    end
  end
  // Toggling stale data makes a read outside the strobe visible as a wrong sum.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sample_data <= 16'h0000;
    end else if (pend && wait_cnt == 3'h0 && !sample_req) begin
      sample_data <= level;
    end else begin
      sample_data <= ~sample_data;
    end
  end
endmodule : cscc_front_model

// ==== cscc_top_props.sv ====
// Purpose: Concurrent checks on the ports of the conversion control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module cscc_top_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Channel masks.
  input wire logic [7:0] channel_mask_low,
  input wire logic [5:0] channel_mask_high,
  // Front end and status.
  input wire logic sample_req,
  input wire logic [4:0] conv_channel,
  input wire logic multi_channel_short_enable,
  input wire logic [13:0] short_mask,
  input wire logic sample_valid,
  input wire logic conversion_in_progress,
  input wire logic conversion_done_flag,
  input wire logic [7:0] result_high_byte,
  input wire logic [7:0] result_low_byte
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // A start is busy rising; a status read is a read strobe at the control address.
  sequence start_s;
    $rose(conversion_in_progress);
  endsequence
  sequence ctrl_rd_s;
    sfr_rd && sfr_addr == 8'hB0;
  endsequence
  start_req_a: assert property (start_s |-> sample_req)
    else $error("start without sample request");
  busy_req_a: assert property (sample_req |-> conversion_in_progress)
    else $error("sample request while idle");
  req_pulse_a: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  ctrl_read_a: assert property (ctrl_rd_s |=> sfr_rdata ==
    {2'b00, $past(conversion_done_flag), $past(conversion_in_progress), 4'h0})
    else $error("status read mismatch");
  done_sticky_a: assert property (conversion_done_flag && !(sfr_wr && sfr_addr == 8'hB0)
    |=> conversion_done_flag) else $error("done flag cleared by hardware");
  done_cause_a: assert property ($rose(conversion_done_flag) |->
    $past(sample_valid, 2) || $past(sfr_wr)) else $error("done flag without a sample");
  result_done_a: assert property ($changed({result_high_byte, result_low_byte})
    |-> conversion_done_flag) else $error("result changed without done");
  short_mask_a: assert property (short_mask != 14'h0000 |-> multi_channel_short_enable
    && (short_mask & ~$past({channel_mask_high, channel_mask_low})) == 14'h0000)
    else $error("short mask outside enabled mask");
  channel_hold_a: assert property (sample_valid |-> $stable(conv_channel))
    else $error("channel moved during a sample");
endmodule : cscc_top_props
bind cscc_top cscc_top_props u_props (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .channel_mask_low(channel_mask_low), .channel_mask_high(channel_mask_high),
  .sample_req(sample_req), .conv_channel(conv_channel),
  .multi_channel_short_enable(multi_channel_short_enable), .short_mask(short_mask),
  .sample_valid(sample_valid), .conversion_in_progress(conversion_in_progress),
  .conversion_done_flag(conversion_done_flag), .result_high_byte(result_high_byte),
  .result_low_byte(result_low_byte));

// ==== cscc_top_bench.sv ====
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Inputs change at the falling edge; the design samples on the rising edge.
// Notes: Results and read data are compared in order against queued notes.
`timescale 1ns/1ps
module cscc_top_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] channel_mask_low = 8'h00;
  logic [5:0] channel_mask_high = 6'h00;
  logic [4:0] input_mux_select = 5'h09;
  logic [4:0] scan_first_channel = 5'h02;
  logic [4:0] scan_last_channel = 5'h05;
  logic [3:0] timer_overflow = 4'h0;
  logic [15:0] level = 16'h0000;
  logic slow = 1'b0;
  logic [7:0] sfr_rdata, result_high_byte, result_low_byte;
  logic [4:0] conv_channel;
  logic [13:0] short_mask;
  logic [15:0] sample_data;
  logic sample_req, multi_channel_short_enable, sample_valid;
  logic conversion_in_progress, conversion_done_flag;
  logic rd_q = 1'b0;
  logic done_q = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 95088;
  int cycles = 0;
  logic [15:0] resq[$];
  logic [15:0] rdq[$];
  logic [4:0] chq[$];
  cscc_top dut (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .channel_mask_low(channel_mask_low), .channel_mask_high(channel_mask_high),
    .input_mux_select(input_mux_select), .scan_first_channel(scan_first_channel),
    .scan_last_channel(scan_last_channel), .timer_overflow(timer_overflow),
    .sample_req(sample_req), .conv_channel(conv_channel),
    .multi_channel_short_enable(multi_channel_short_enable), .short_mask(short_mask),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .conversion_in_progress(conversion_in_progress),
    .conversion_done_flag(conversion_done_flag), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte));
  cscc_front_model u_front (.clk_sys(clk_sys), .srst(srst), .sample_req(sample_req),
    .slow(slow), .level(level), .sample_valid(sample_valid), .sample_data(sample_data));
  // The clock toggles every half period of 2.5 ns.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    rdq.push_back({8'h00, e});
    @(negedge clk_sys);
    sfr_rd = 1'b0;
  endtask : rd
  task automatic pulse(input logic [3:0] v);
    @(negedge clk_sys);
    timer_overflow = v;
    @(negedge clk_sys);
    timer_overflow = 4'h0;
  endtask : pulse
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 3000 && conversion_in_progress !== v; i++) @(negedge clk_sys);
    chk("busy", {15'h0000, v}, {15'h0000, conversion_in_progress});
  endtask : wait_busy
  // Starts a mode, collects num requests, then leaves it by choosing software start.
  task automatic scan(input logic [7:0] cfg, input int num);
    chq.delete();
    wr(8'hAA, cfg);
    wr(8'hB0, 8'h10);
    for (int i = 0; i < 3000 && chq.size() < num; i++) @(negedge clk_sys);
    wr(8'hAA, 8'h00);
    wait_busy(1'b0);
    wr(8'hB0, 8'h00);
  endtask : scan
  function automatic int nsamp(input logic [2:0] c);
    return (c == 3'h0 || c > 3'h5) ? 1 : 2 << c;
  endfunction : nsamp
  // The watcher pops the oldest note whenever read data appears, or when the done flag rises while a result note is queued.
  always @(posedge clk_sys) begin
    cycles++;
    if (rd_q) chk("rdata", rdq.pop_front(), {8'h00, sfr_rdata});
    if (conversion_done_flag && !done_q && resq.size() > 0)
      chk("result", resq.pop_front(), {result_high_byte, result_low_byte});
    if (sample_req) chq.push_back(conv_channel);
    rd_q <= sfr_rd;
    done_q <= conversion_done_flag;
    if (cycles == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    int s;
    int k;
    int tix[5] = '{0, 0, 2, 1, 3};
    logic [13:0] m;
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    rd(8'hAA, 8'h00);
    rd(8'hB0, 8'h00);
    rd(8'hEE, 8'h00);
    rd(8'h55, 8'h00);
    s = $random(seed);
    if (s[2:1] == 2'b11) s[1] = 1'b0;
    wr(8'hAA, s[7:0]);
    rd(8'hAA, s[7:0]);
    // Software start across every accumulate code, alternating partner speed.
    for (int c = 0; c < 8; c++) begin
      level = 16'($random(seed));
      slow = c[0];
      s = nsamp(c[2:0]) * level;
      s = s > 65535 ? 65535 : s;
      resq.push_back(s[15:0]);
      wr(8'hAA, {5'h00, c[2:0]});
      wr(8'hB0, 8'h10);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(8'hB0, 8'h20);
      rd(8'hED, s[7:0]);
      rd(8'hEE, s[15:8]);
      wr(8'hB0, 8'h00);
    end
    // Timer starts: other timers are ignored, and so is a pulse while busy.
    for (int t = 1; t < 5; t++) begin
      level = 16'($random(seed));
      slow = 1'b1;
      wr(8'hAA, {1'b0, 3'(t), 4'h0});
      pulse(~(4'h1 << tix[t]));
      repeat (4) @(negedge clk_sys);
      chk("idle", 16'h0000, {15'h0000, conversion_in_progress});
      resq.push_back(level);
      pulse(4'h1 << tix[t]);
      wait_busy(1'b1);
      pulse(4'hF);
      wait_busy(1'b0);
      repeat (3) @(negedge clk_sys);
      chk("restart", 16'h0000, {15'h0000, conversion_in_progress});
      wr(8'hB0, 8'h00);
    end
    wr(8'hAA, 8'h50);
    wr(8'hB0, 8'h10);
    repeat (4) @(negedge clk_sys);
    chk("reserved", 16'h0000, {15'h0000, conversion_in_progress});
    m = 14'($random(seed)) | 14'h0001;
    {channel_mask_high, channel_mask_low} = m;
    k = $countones(m);
    scan(8'hD0, k);
    chk("single_pass", 16'(k), 16'(chq.size()));
    foreach (chq[i]) chk("in_mask", 16'h0001, {15'h0000, m[chq[i]]});
    scan(8'hF0, 2 * k + 1);
    chk("repeat", 16'h0001, {15'h0000, chq.size() > 2 * k});
    foreach (chq[i]) chk("in_mask", 16'h0001, {15'h0000, m[chq[i]]});
    scan(8'h70, 8);
    for (int i = 0; i < 8; i++) chk("range_ch", 16'(2 + i % 4), {11'h000, chq[i]});
    scan(8'h60, 3);
    for (int i = 0; i < 3; i++) chk("mux_ch", 16'h0009, {11'h000, chq[i]});
    wr(8'hAA, 8'h88);
    repeat (2) @(negedge clk_sys);
    chk("short_mask", {2'b00, m}, {2'b00, short_mask});
    wr(8'hAA, 8'h08);
    repeat (2) @(negedge clk_sys);
    chk("short_off", 16'h0000, {2'b00, short_mask});
    chk("multi", 16'h0001, {15'h0000, multi_channel_short_enable});
    scan(8'hD8, 1);
    chk("one_node", 16'h0001, 16'(chq.size()));
    repeat (3) @(negedge clk_sys);
    summarize();
  end
endmodule : cscc_top_bench
